/* File: src/rtal_pkg.sv */
// Constants for the alarm and oscillator load-trim block
// Function
// - Trim top bit: clear adds, set removes
// - Seven trim bits binary-weighted, 0.25 to 16 pF
// - Zero magnitude selects nominal load, any sign
// - Invalid trim code falls back to default
// - Test and level bits, not stopped: 512 Hz
// - Test tone taken ahead of digital correction
// - Alarm one and two in separate address ranges
// - Each alarm matches fields or repeats independently
// - Undefined repeat code means once per second
// - Match under repeat criteria sets alarm flag
// - Alarm one with enable drives the pin
// - No flag while pointer rests on flags
// - Flags read clears flags and releases pin
// - Clearing read still returns flag set
// - Alarms and pin work on backup battery
// - Second alarm only with enable; else storage
// - Repeat code table, highest bit first
package rtal_pkg;

	// Register addresses
	localparam logic [6:0] RTAL_ADDR_CTRL  = 7'h08;
	localparam logic [6:0] RTAL_ADDR_ALM1  = 7'h0A;
	localparam logic [6:0] RTAL_ADDR_FLAGS = 7'h0F;
	localparam logic [6:0] RTAL_ADDR_TRIM  = 7'h12;
	localparam logic [6:0] RTAL_ADDR_CFG   = 7'h13;
	localparam logic [6:0] RTAL_ADDR_ALM2  = 7'h14;
	localparam logic [6:0] RTAL_ALM_REGS   = 7'h05;

	// Slots inside one alarm's range
	localparam logic [2:0] RTAL_IDX_MON  = 3'h0;
	localparam logic [2:0] RTAL_IDX_DATE = 3'h1;
	localparam logic [2:0] RTAL_IDX_HOUR = 3'h2;
	localparam logic [2:0] RTAL_IDX_MIN  = 3'h3;
	localparam logic [2:0] RTAL_IDX_SEC  = 3'h4;

	// Bit positions
	localparam int RTAL_FLAG_AF1_BIT = 6;
	localparam int RTAL_FLAG_AF2_BIT = 5;
	localparam int RTAL_CTRL_OUT_BIT = 7;
	localparam int RTAL_CTRL_FT_BIT  = 6;
	localparam int RTAL_CTRL_ST_BIT  = 5;
	localparam int RTAL_CFG_ALARM_TWO_ENABLE_BIT = 1;
	localparam int RTAL_IRQEN_BIT    = 7;
	localparam int RTAL_RPT_BIT      = 7;
	localparam int RTAL_RPT_MON_BIT  = 6;
	localparam int RTAL_TRIM_SIGN    = 7;
	localparam int RTAL_CMD_WR_BIT   = 7;

	// Compare masks per time field
	localparam logic [7:0] RTAL_MON_MASK  = 8'h1F;
	localparam logic [7:0] RTAL_DATE_MASK = 8'h3F;
	localparam logic [7:0] RTAL_HOUR_MASK = 8'h3F;
	localparam logic [7:0] RTAL_MIN_MASK  = 8'h7F;
	localparam logic [7:0] RTAL_SEC_MASK  = 8'h7F;

	// Repeat codes
	localparam logic [4:0] RTAL_RPT_SECOND = 5'h1F;
	localparam logic [4:0] RTAL_RPT_MINUTE = 5'h1E;
	localparam logic [4:0] RTAL_RPT_HOUR   = 5'h1C;
	localparam logic [4:0] RTAL_RPT_DAY    = 5'h18;
	localparam logic [4:0] RTAL_RPT_MONTH  = 5'h10;
	localparam logic [4:0] RTAL_RPT_YEAR   = 5'h00;

	// Load capacitance per side, in quarter-picofarad units
	localparam logic [7:0] RTAL_CAP_DEFAULT  = 8'h64;
	localparam logic [6:0] RTAL_TRIM_MAX_ADD = 7'h27;
	localparam logic [6:0] RTAL_TRIM_MAX_REM = 7'h48;

	// Reset values
	localparam logic [7:0] RTAL_CTRL_RST = 8'h80;
	localparam logic [7:0] RTAL_CFG_RST  = 8'h00;
	localparam logic [7:0] RTAL_TRIM_RST = 8'h00;
	localparam logic [7:0] RTAL_ALM_RST  = 8'h00;
	localparam logic [2:0] RTAL_BIT_LAST = 3'h7;

	typedef enum logic [1:0] {RTAL_SPI_CMD, RTAL_SPI_WR, RTAL_SPI_RD} rtal_spi_e;

endpackage

/* File: src/rtal_alarm_match.sv */
// Alarm field comparator with repeat-mode masking
module rtal_alarm_match (
	// Alarm settings
	input  wire logic [7:0] mon_i,
	input  wire logic [7:0] date_i,
	input  wire logic [7:0] hour_i,
	input  wire logic [7:0] min_i,
	input  wire logic [7:0] sec_i,
	// Running time
	input  wire logic [7:0] cur_mon_i,
	input  wire logic [7:0] cur_date_i,
	input  wire logic [7:0] cur_hour_i,
	input  wire logic [7:0] cur_min_i,
	input  wire logic [7:0] cur_sec_i,
	// Result
	output logic            match_o
);

	// Fields that must match, order {mon, date, hour, min, sec}
	function automatic logic [4:0] rtal_need(input logic [4:0] rpt);
		case (rpt)
			rtal_pkg::RTAL_RPT_SECOND: rtal_need = 5'h00;
			rtal_pkg::RTAL_RPT_MINUTE: rtal_need = 5'h01;
			rtal_pkg::RTAL_RPT_HOUR:   rtal_need = 5'h03;
			rtal_pkg::RTAL_RPT_DAY:    rtal_need = 5'h07;
			rtal_pkg::RTAL_RPT_MONTH:  rtal_need = 5'h0F;
			rtal_pkg::RTAL_RPT_YEAR:   rtal_need = 5'h1F;
			default:                   rtal_need = 5'h00;
		endcase
	endfunction

	logic [4:0] rpt;
	logic [4:0] eq;
	logic [4:0] need;

	assign rpt  = {mon_i[rtal_pkg::RTAL_RPT_MON_BIT], date_i[rtal_pkg::RTAL_RPT_BIT],
		hour_i[rtal_pkg::RTAL_RPT_BIT], min_i[rtal_pkg::RTAL_RPT_BIT],
		sec_i[rtal_pkg::RTAL_RPT_BIT]};
	assign eq[4] = (mon_i & rtal_pkg::RTAL_MON_MASK) == (cur_mon_i & rtal_pkg::RTAL_MON_MASK);
	assign eq[3] = (date_i & rtal_pkg::RTAL_DATE_MASK) == (cur_date_i & rtal_pkg::RTAL_DATE_MASK);
	assign eq[2] = (hour_i & rtal_pkg::RTAL_HOUR_MASK) == (cur_hour_i & rtal_pkg::RTAL_HOUR_MASK);
	assign eq[1] = (min_i & rtal_pkg::RTAL_MIN_MASK) == (cur_min_i & rtal_pkg::RTAL_MIN_MASK);
	assign eq[0] = (sec_i & rtal_pkg::RTAL_SEC_MASK) == (cur_sec_i & rtal_pkg::RTAL_SEC_MASK);
	assign need = rtal_need(rpt);
	// A zero date never occurs, so year mode with date zero stays silent
	assign match_o = &(~need | eq);

endmodule // rtal_alarm_match

/* File: src/rtal_trim_decode.sv */
// Load-trim register decode into per-side capacitance code
module rtal_trim_decode (
	// Trim register
	input  wire logic [7:0] trim_i,
	// Capacitance per side, quarter-picofarad units
	output logic [7:0]      cap_o
);

	logic       trim_sign;
	logic [6:0] trim_magnitude;
	logic       mag_zero;
	logic       code_valid;
	logic [7:0] cap_add;
	logic [7:0] cap_rem;

	assign trim_sign      = trim_i[rtal_pkg::RTAL_TRIM_SIGN];
	assign trim_magnitude = trim_i[6:0];
	assign mag_zero       = trim_magnitude == 7'h00;
	// Removal range is wider than addition
	assign code_valid = trim_sign ? (trim_magnitude <= rtal_pkg::RTAL_TRIM_MAX_REM)
		: (trim_magnitude <= rtal_pkg::RTAL_TRIM_MAX_ADD);
	// Magnitude counts quarters of a picofarad, weights 0.25 to 16
	assign cap_add = rtal_pkg::RTAL_CAP_DEFAULT + {1'b0, trim_magnitude};
	assign cap_rem = rtal_pkg::RTAL_CAP_DEFAULT - {1'b0, trim_magnitude};
	assign cap_o = (mag_zero || !code_valid) ? rtal_pkg::RTAL_CAP_DEFAULT
		: (trim_sign ? cap_rem : cap_add);

endmodule // rtal_trim_decode

/* File: src/rtal_top.sv */
// Alarm, flags, load-trim and test-pin logic behind the serial port
module rtal_top (
	// Clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       reset_i,
	input  wire logic       ce_i,
	// Serial peripheral port, mode 0
	input  wire logic       scl_i,
	input  wire logic       sdi_i,
	input  wire logic       chip_en_n_i,
	output logic            sdo_o,
	output logic            sdo_oe_n_o,
	// Running time from the clock counters, BCD
	input  wire logic [7:0] cur_month_i,
	input  wire logic [7:0] cur_date_i,
	input  wire logic [7:0] cur_hour_i,
	input  wire logic [7:0] cur_minute_i,
	input  wire logic [7:0] cur_second_i,
	input  wire logic       tick_1hz_i,
	input  wire logic       div_512hz_i,
	input  wire logic       on_battery_i,
	// Open-drain interrupt and test pin
	output logic            irq_test_pin_o,
	output logic            irq_test_pin_oe_n_o,
	// Load capacitor selections
	output logic [7:0]      input_side_load_cap_o,
	output logic [7:0]      output_side_load_cap_o
);

	// Register slot of an alarm range: {hit, index}
	function automatic logic [3:0] rtal_slot(input logic [6:0] p, input logic [6:0] base);
		logic [6:0] off;
		off = p - base;
		rtal_slot = {off < rtal_pkg::RTAL_ALM_REGS, off[2:0]};
	endfunction

	// Serial engine state
	rtal_pkg::rtal_spi_e spi_q;
	rtal_pkg::rtal_spi_e spi_d;
	logic [2:0]          cnt_q;
	logic [2:0]          cnt_d;
	logic [7:0]          rx_q;
	logic [7:0]          tx_q;
	logic [7:0]          tx_d;
	logic [6:0]          ptr_q;
	logic [6:0]          ptr_d;
	logic                scl_q;

	// Register file
	logic [7:0] alm1_q [0:4];
	logic [7:0] alm2_q [0:4];
	logic [7:0] ctrl_q;
	logic [7:0] cfg_q;
	logic [7:0] trim_q;
	logic       af1_q;
	logic       af2_q;
	logic       pend1_q;
	logic       pend2_q;
	logic       pin_oe_n_q;
	logic [7:0] cap_q;

	// Decode and strobes
	logic       sel;
	logic       rise;
	logic       fall;
	logic       byte_done;
	logic [7:0] rx_byte;
	logic       cmd_done;
	logic       wr_stb;
	logic       rd_load;
	logic       flag_rd;
	logic [3:0] slot1;
	logic [3:0] slot2;
	logic [7:0] flags_val;
	logic [7:0] rd_data;

	// Alarm path
	logic       match1;
	logic       match2;
	logic       al2_en;
	logic       at_flags;
	logic       hit1;
	logic       hit2;
	logic       set1;
	logic       set2;

	// Pin path
	logic       ft_on;
	logic       alarm_irq;
	logic       drive_low;
	logic [7:0] cap_dec;

	// The serial port is cut off while on backup power
	assign sel  = ~chip_en_n_i & ~on_battery_i;
	assign rise = sel & scl_i & ~scl_q;
	assign fall = sel & ~scl_i & scl_q;

	assign byte_done = rise && (cnt_q == rtal_pkg::RTAL_BIT_LAST);
	assign rx_byte   = {rx_q[6:0], sdi_i};
	assign cmd_done  = byte_done && (spi_q == rtal_pkg::RTAL_SPI_CMD);
	assign wr_stb    = byte_done && (spi_q == rtal_pkg::RTAL_SPI_WR);
	// Next read byte is fetched on the falling edge after a byte boundary
	// Limitation: a read that ends just below the flags address prefetches
	// them, and so clears them without the host ever seeing the value
	assign rd_load   = fall && (spi_q == rtal_pkg::RTAL_SPI_RD) && (cnt_q == 3'h0);
	assign flag_rd   = rd_load && (ptr_q == rtal_pkg::RTAL_ADDR_FLAGS);

	assign slot1 = rtal_slot(ptr_q, rtal_pkg::RTAL_ADDR_ALM1);
	assign slot2 = rtal_slot(ptr_q, rtal_pkg::RTAL_ADDR_ALM2);

	assign flags_val = ({7'h00, af1_q} << rtal_pkg::RTAL_FLAG_AF1_BIT)
		| ({7'h00, af2_q} << rtal_pkg::RTAL_FLAG_AF2_BIT);

	// Unmapped addresses read as zero
	assign rd_data = slot1[3] ? alm1_q[slot1[2:0]]
		: slot2[3] ? alm2_q[slot2[2:0]]
		: (ptr_q == rtal_pkg::RTAL_ADDR_FLAGS) ? flags_val
		: (ptr_q == rtal_pkg::RTAL_ADDR_CTRL) ? ctrl_q
		: (ptr_q == rtal_pkg::RTAL_ADDR_CFG) ? cfg_q
		: (ptr_q == rtal_pkg::RTAL_ADDR_TRIM) ? trim_q
		: 8'h00;

	// Serial engine next state
	always_comb begin
		spi_d = spi_q;
		cnt_d = cnt_q;
		ptr_d = ptr_q;
		tx_d  = tx_q;
		if (!sel) begin
			spi_d = rtal_pkg::RTAL_SPI_CMD;
			cnt_d = 3'h0;
		end else begin
			if (rise) begin
				cnt_d = cnt_q + 3'h1;
			end
			if (cmd_done) begin
				ptr_d = rx_byte[6:0];
				spi_d = rx_byte[rtal_pkg::RTAL_CMD_WR_BIT] ? rtal_pkg::RTAL_SPI_WR
					: rtal_pkg::RTAL_SPI_RD;
			end else if (wr_stb || rd_load) begin
				// Pointer keeps its place between frames
				ptr_d = ptr_q + 7'h01;
			end
			if (rd_load) begin
				// Flags are captured before they clear
				tx_d = rd_data;
			end else if (fall && spi_q == rtal_pkg::RTAL_SPI_RD) begin
				tx_d = {tx_q[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			spi_q <= rtal_pkg::RTAL_SPI_CMD;
			cnt_q <= 3'h0;
			ptr_q <= 7'h00;
			tx_q  <= 8'h00;
		end else if (ce_i) begin
			spi_q <= spi_d;
			cnt_q <= cnt_d;
			ptr_q <= ptr_d;
			tx_q  <= tx_d;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			rx_q  <= 8'h00;
			scl_q <= 1'b0;
		end else if (ce_i) begin
			scl_q <= scl_i;
			if (rise) begin
				rx_q <= rx_byte;
			end
		end
	end

	// Write frames never drive back, so the host never fights the block
	assign sdo_o      = tx_q[7];
	assign sdo_oe_n_o = ~(sel && spi_q == rtal_pkg::RTAL_SPI_RD);

	// Alarm registers; the second range is plain storage while disabled
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			for (int i = 0; i < 5; i++) begin
				alm1_q[i] <= rtal_pkg::RTAL_ALM_RST;
				alm2_q[i] <= rtal_pkg::RTAL_ALM_RST;
			end
		end else if (ce_i && wr_stb) begin
			if (slot1[3]) begin
				alm1_q[slot1[2:0]] <= rx_byte;
			end
			if (slot2[3]) begin
				alm2_q[slot2[2:0]] <= rx_byte;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			ctrl_q <= rtal_pkg::RTAL_CTRL_RST;
			cfg_q  <= rtal_pkg::RTAL_CFG_RST;
			trim_q <= rtal_pkg::RTAL_TRIM_RST;
		end else if (ce_i && wr_stb) begin
			if (ptr_q == rtal_pkg::RTAL_ADDR_CTRL) begin
				ctrl_q <= rx_byte;
			end
			if (ptr_q == rtal_pkg::RTAL_ADDR_CFG) begin
				cfg_q <= rx_byte;
			end
			if (ptr_q == rtal_pkg::RTAL_ADDR_TRIM) begin
				trim_q <= rx_byte;
			end
		end
	end

	rtal_alarm_match u_match1 (
		.mon_i      (alm1_q[rtal_pkg::RTAL_IDX_MON]),
		.date_i     (alm1_q[rtal_pkg::RTAL_IDX_DATE]),
		.hour_i     (alm1_q[rtal_pkg::RTAL_IDX_HOUR]),
		.min_i      (alm1_q[rtal_pkg::RTAL_IDX_MIN]),
		.sec_i      (alm1_q[rtal_pkg::RTAL_IDX_SEC]),
		.cur_mon_i  (cur_month_i),
		.cur_date_i (cur_date_i),
		.cur_hour_i (cur_hour_i),
		.cur_min_i  (cur_minute_i),
		.cur_sec_i  (cur_second_i),
		.match_o    (match1)
	);

	rtal_alarm_match u_match2 (
		.mon_i      (alm2_q[rtal_pkg::RTAL_IDX_MON]),
		.date_i     (alm2_q[rtal_pkg::RTAL_IDX_DATE]),
		.hour_i     (alm2_q[rtal_pkg::RTAL_IDX_HOUR]),
		.min_i      (alm2_q[rtal_pkg::RTAL_IDX_MIN]),
		.sec_i      (alm2_q[rtal_pkg::RTAL_IDX_SEC]),
		.cur_mon_i  (cur_month_i),
		.cur_date_i (cur_date_i),
		.cur_hour_i (cur_hour_i),
		.cur_min_i  (cur_minute_i),
		.cur_sec_i  (cur_second_i),
		.match_o    (match2)
	);

	// Matching ignores battery state on purpose
	assign al2_en   = cfg_q[rtal_pkg::RTAL_CFG_ALARM_TWO_ENABLE_BIT];
	assign hit1     = tick_1hz_i & match1;
	assign hit2     = tick_1hz_i & match2 & al2_en;
	assign at_flags = ptr_q == rtal_pkg::RTAL_ADDR_FLAGS;
	// Held matches land once the pointer leaves the flags address
	assign set1 = ~at_flags & (hit1 | pend1_q);
	assign set2 = ~at_flags & (hit2 | pend2_q);

	// Hits while parked collapse into one pending event per alarm
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			pend1_q <= 1'b0;
			pend2_q <= 1'b0;
		end else if (ce_i) begin
			pend1_q <= at_flags & (pend1_q | hit1);
			pend2_q <= at_flags & (pend2_q | hit2);
		end
	end

	// A hit during a clearing read is held pending and sets the flag the cycle after
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			af1_q <= 1'b0;
			af2_q <= 1'b0;
		end else if (ce_i) begin
			af1_q <= set1 | (af1_q & ~flag_rd);
			af2_q <= set2 | (af2_q & ~flag_rd);
		end
	end

	// Test tone uses the raw divider tap, untouched by counter correction
	assign ft_on = ctrl_q[rtal_pkg::RTAL_CTRL_FT_BIT] & ctrl_q[rtal_pkg::RTAL_CTRL_OUT_BIT]
		& ~ctrl_q[rtal_pkg::RTAL_CTRL_ST_BIT];
	// Alarm two only raises its flag; it never pulls the pin
	assign alarm_irq = af1_q & alm1_q[rtal_pkg::RTAL_IDX_MON][rtal_pkg::RTAL_IRQEN_BIT];
	assign drive_low = ft_on ? ~div_512hz_i
		: (alarm_irq | ~ctrl_q[rtal_pkg::RTAL_CTRL_OUT_BIT]);

	rtal_trim_decode u_trim (
		.trim_i (trim_q),
		.cap_o  (cap_dec)
	);

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			pin_oe_n_q <= 1'b1;
			cap_q      <= rtal_pkg::RTAL_CAP_DEFAULT;
		end else if (ce_i) begin
			pin_oe_n_q <= ~drive_low;
			cap_q      <= cap_dec;
		end
	end

	// Open drain: only ever pulls low
	assign irq_test_pin_o         = 1'b0;
	assign irq_test_pin_oe_n_o    = pin_oe_n_q;
	assign input_side_load_cap_o  = cap_q;
	assign output_side_load_cap_o = cap_q;

endmodule // rtal_top

/* File: sim/rtal_top_asserts.sv */
// Port-level checker for the alarm and load-trim block
module rtal_top_asserts (
	// Clock and reset
	input wire logic       sys_clk_i,
	input wire logic       reset_i,
	// Serial port
	input wire logic       chip_en_n_i,
	input wire logic       sdo_oe_n_o,
	// Timing and supply
	input wire logic       tick_1hz_i,
	input wire logic       div_512hz_i,
	input wire logic       on_battery_i,
	// Pin and trim outputs
	input wire logic       irq_test_pin_o,
	input wire logic       irq_test_pin_oe_n_o,
	input wire logic [7:0] input_side_load_cap_o,
	input wire logic [7:0] output_side_load_cap_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	// Host idle long enough for any pointer move to have landed
	sequence s_bus_quiet;
		chip_en_n_i [*3];
	endsequence
	sequence s_pin_drop;
		$fell(irq_test_pin_oe_n_o) && div_512hz_i && $past(div_512hz_i)
			&& $past(div_512hz_i, 2);
	endsequence
	property p_alarm_cause;
		s_bus_quiet ##0 s_pin_drop |-> $past(tick_1hz_i, 2);
	endproperty

	chk_caps_sides_equal: assert property (
		input_side_load_cap_o == output_side_load_cap_o)
		else $error("load cap sides differ");
	chk_caps_in_range: assert property (
		input_side_load_cap_o inside {[8'h1C:8'h8B]})
		else $error("load cap outside trim range");
	chk_caps_hold_idle: assert property (
		s_bus_quiet |-> $stable(input_side_load_cap_o))
		else $error("load cap moved without a write");
	chk_caps_hold_battery: assert property (
		on_battery_i && $past(on_battery_i, 3) |-> $stable(output_side_load_cap_o))
		else $error("load cap moved on backup supply");
	chk_pin_open_drain: assert property (
		irq_test_pin_o == 1'b0)
		else $error("pin value not open drain");
	chk_sdo_quiet_deselect: assert property (
		chip_en_n_i || on_battery_i |-> sdo_oe_n_o)
		else $error("sdo driven while deselected");
	chk_reset_defaults: assert property (
		disable iff (1'b0) reset_i |=> input_side_load_cap_o == 8'h64 && irq_test_pin_oe_n_o)
		else $error("reset state wrong");
	chk_alarm_pin_cause: assert property (
		p_alarm_cause)
		else $error("pin asserted without tick");
endmodule // rtal_top_asserts

bind rtal_top rtal_top_asserts u_rtal_top_asserts (.sys_clk_i, .reset_i, .chip_en_n_i,
	.sdo_oe_n_o, .tick_1hz_i, .div_512hz_i, .on_battery_i, .irq_test_pin_o,
	.irq_test_pin_oe_n_o, .input_side_load_cap_o, .output_side_load_cap_o);

/* File: sim/rtal_host_model.sv */
// Serial host model driving the block's mode 0 port
module rtal_host_model (
	// Clock
	input  wire logic       clk_i,
	// Serial port
	input  wire logic       sdo_i,
	output logic            scl_o,
	output logic            sdi_o,
	output logic            chip_en_n_o,
	// Read result
	output logic [7:0]      rd_data_o,
	output logic            rd_valid_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Half period of scl in system cycles, raised by the bench for a slow host
	int hold = 2;
	initial begin
		scl_o = 1'b0;
		sdi_o = 1'b0;
		chip_en_n_o = 1'b1;
		rd_data_o = 8'h00;
		rd_valid_o = 1'b0;
	end
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			@(negedge clk_i) sdi_o = tx[i];
			repeat (hold) @(negedge clk_i);
			scl_o = 1'b1;
			rx[i] = sdo_i;
			repeat (hold) @(negedge clk_i);
			scl_o = 1'b0;
		end
	endtask
	task automatic frame(input logic [7:0] cmd, input logic [7:0] d, output logic [7:0] rx);
		logic [7:0] junk;
		@(negedge clk_i) chip_en_n_o = 1'b0;
		xfer(cmd, junk);
		xfer(d, rx);
		repeat (4) @(negedge clk_i);
		chip_en_n_o = 1'b1;
		// Released line must not keep its last value
		sdi_o = ~sdi_o;
		repeat (2) @(negedge clk_i);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] rx;
		frame({1'b1, a}, d, rx);
	endtask
	task automatic rd(input logic [6:0] a);
		logic [7:0] rx;
		frame({1'b0, a}, 8'hA5, rx);
		rd_data_o = rx;
		rd_valid_o = 1'b1;
		@(negedge clk_i) rd_valid_o = 1'b0;
	endtask
endmodule // rtal_host_model

/* File: sim/tb.sv */
// Self-checking bench for the alarm and load-trim block
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic       sys_clk_i = 1'b0;
	logic       reset_i = 1'b1;
	logic       tick_1hz_i = 1'b0;
	logic       div_512hz_i = 1'b1;
	logic       on_battery_i = 1'b0;
	logic       scl, sdi, cen_n, sdo, sdo_oe_n, pin, pin_oe_n, rd_valid;
	logic [7:0] cap_in, cap_out, rd_data, v, exp_q[$];
	logic [7:0] cur[5] = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
	logic [7:0] alm[5] = '{8'h05, 8'h12, 8'h08, 8'h30, 8'h45};
	logic [7:0] trims[7] = '{8'h80, 8'h0C, 8'h27, 8'h28, 8'hC8, 8'hC9, 8'h9C};
	logic [4:0] codes[7] = '{5'h1F, 5'h1E, 5'h1C, 5'h18, 5'h10, 5'h00, 5'h15};
	int         nreq[7] = '{0, 1, 2, 3, 4, 5, 0};
	int         err_total = 0, n_compared = 0, seed = 66109;
	logic       ce = 1'b1;
	// Both lines have pull-ups, so a missing drive enable shows as ones
	wire        sdo_line = sdo_oe_n ? 1'b1 : sdo;
	wire        pin_line = pin_oe_n ? 1'b1 : pin;
	wire [7:0]  pin8 = {7'h00, pin_line};

	always #5 sys_clk_i = ~sys_clk_i;

	rtal_top u_rtal_top (.sys_clk_i, .reset_i, .ce_i(ce), .scl_i(scl), .sdi_i(sdi),
		.chip_en_n_i(cen_n), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n), .cur_month_i(cur[0]),
		.cur_date_i(cur[1]), .cur_hour_i(cur[2]), .cur_minute_i(cur[3]),
		.cur_second_i(cur[4]), .tick_1hz_i, .div_512hz_i, .on_battery_i,
		.irq_test_pin_o(pin), .irq_test_pin_oe_n_o(pin_oe_n),
		.input_side_load_cap_o(cap_in), .output_side_load_cap_o(cap_out));
	rtal_host_model u_host (.clk_i(sys_clk_i), .sdo_i(sdo_line), .scl_o(scl), .sdi_o(sdi),
		.chip_en_n_o(cen_n), .rd_data_o(rd_data), .rd_valid_o(rd_valid));

	task automatic check(input logic [7:0] seen, input logic [7:0] expd);
		n_compared++;
		if (seen !== expd) begin
			err_total++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, expd);
		end
	endtask
	task automatic test_done;
		$display("errors %0d, comparisons %0d", err_total, n_compared);
		if (err_total == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	function automatic logic [7:0] cap_exp(input logic [7:0] t);
		if (!t[7] && t[6:0] <= 7'h27) return 8'h64 + {1'b0, t[6:0]};
		if (t[7] && t[6:0] <= 7'h48) return 8'h64 - {1'b0, t[6:0]};
		return 8'h64;
	endfunction
	task automatic rd_exp(input logic [6:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		u_host.rd(a);
	endtask
	task automatic tick;
		@(negedge sys_clk_i) tick_1hz_i = 1'b1;
		@(negedge sys_clk_i) tick_1hz_i = 1'b0;
		repeat (4) @(negedge sys_clk_i);
	endtask
	task automatic set_alarm(input logic [6:0] b, input logic [4:0] c, input logic ien);
		u_host.wr(b, {ien, c[4], 6'h05});
		u_host.wr(b + 7'h01, {c[3], 7'h12});
		u_host.wr(b + 7'h02, {c[2], 7'h08});
		u_host.wr(b + 7'h03, {c[1], 7'h30});
		u_host.wr(b + 7'h04, {c[0], 7'h45});
	endtask

	// Oldest expected read result against each returned byte
	always @(posedge sys_clk_i) begin
		if (rd_valid === 1'b1)
			check(rd_data, exp_q.pop_front());
	end

	initial begin
		repeat (10) @(negedge sys_clk_i);
		reset_i = 1'b0;
		check(cap_in, 8'h64);
		rd_exp(7'h12, 8'h00);
		for (int k = 0; k < 11; k++) begin
			v = (k < 7) ? trims[k] : 8'($random(seed));
			u_host.wr(7'h12, v);
			check(cap_in, cap_exp(v));
			check(cap_out, cap_exp(v));
			rd_exp(7'h12, v);
		end
		u_host.wr(7'h12, 8'h00);
		cur = alm;
		// Last write to alarm seconds leaves the pointer on the flags
		set_alarm(7'h0A, 5'h00, 1'b1);
		tick;
		check(pin8, 8'h01);
		rd_exp(7'h12, 8'h00);
		check(pin8, 8'h00);
		rd_exp(7'h0F, 8'h40);
		check(pin8, 8'h01);
		rd_exp(7'h0F, 8'h00);
		cur[4] = 8'h46;
		tick;
		rd_exp(7'h0F, 8'h00);
		cur = alm;
		on_battery_i = 1'b1;
		// Port is cut off on backup supply, so this write must be lost
		u_host.wr(7'h12, 8'h0C);
		tick;
		check(pin8, 8'h00);
		check(cap_in, 8'h64);
		on_battery_i = 1'b0;
		rd_exp(7'h0F, 8'h40);
		rd_exp(7'h12, 8'h00);
		u_host.hold = 4;
		for (int k = 0; k < 7; k++) begin
			set_alarm(7'h0A, codes[k], 1'b1);
			rd_exp(7'h12, 8'h00);
			for (int i = 0; i < 5; i++)
				cur[i] = (4 - i < nreq[k]) ? alm[i] : alm[i] + 8'h01;
			tick;
			rd_exp(7'h0F, 8'h40);
			cur[4] = 8'h46;
			tick;
			rd_exp(7'h0F, (nreq[k] == 0) ? 8'h40 : 8'h00);
		end
		u_host.hold = 2;
		// A tick while frozen is never seen, so no event follows it
		ce = 1'b0;
		tick;
		ce = 1'b1;
		check(pin8, 8'h01);
		rd_exp(7'h0F, 8'h00);
		tick;
		rd_exp(7'h0F, 8'h40);
		cur = alm;
		set_alarm(7'h0A, 5'h00, 1'b0);
		u_host.wr(7'h0B, 8'h00);
		tick;
		rd_exp(7'h0F, 8'h00);
		set_alarm(7'h14, 5'h1F, 1'b1);
		tick;
		rd_exp(7'h0F, 8'h00);
		rd_exp(7'h14, 8'hC5);
		u_host.wr(7'h13, 8'h02);
		tick;
		check(pin8, 8'h01);
		rd_exp(7'h0F, 8'h20);
		u_host.wr(7'h08, 8'hC0);
		for (int j = 0; j < 4; j++) begin
			div_512hz_i = j[0];
			repeat (3) @(negedge sys_clk_i);
			check(pin8, {7'h00, j[0]});
		end
		u_host.wr(7'h08, 8'hE0);
		div_512hz_i = 1'b0;
		repeat (3) @(negedge sys_clk_i);
		check(pin8, 8'h01);
		div_512hz_i = 1'b1;
		u_host.wr(7'h12, 8'h0C);
		check(cap_in, 8'h70);
		// Second reset in mid-run must bring back the power-up values
		reset_i = 1'b1;
		repeat (3) @(negedge sys_clk_i);
		reset_i = 1'b0;
		check(cap_in, 8'h64);
		rd_exp(7'h08, 8'h80);
		rd_exp(7'h13, 8'h00);
		repeat (20) @(negedge sys_clk_i);
		test_done;
	end

	initial begin
		repeat (40000) @(posedge sys_clk_i);
		err_total++;
		test_done;
	end
endmodule // tb
